// *** msa_selective_addressing.sv ***
// multipoint selective addressing: master, selection, ack substitution, transmit enable
// Overview of operation
// - keyboard EOT with nothing received since wake-up makes master, selected, line high
// - each received strobe starts four-slot sequencer, one shift per option clock
// - commands and addresses decoded only in slots t1 and t3, not at t2
// - at t2 network-free flag takes not-master; blocks later master attempt
// - unselected non-master, or address mode except ENQ: at t4 ack replaces char, strobe downstream
// - received EOT clears master, network-free, selected; sets address mode; acked
// - received NULL sets address mode and is replaced by ack
// - in address mode compare code with unique and group switch settings
// - group, unique or BELL match in address mode sets selected
// - matching address codes are replaced by ack and passed on at t4
// - broadcast and group slaves stay transmit disabled, line at zero
// - selected lamp lit only when selected and line is high
// - STX clears address mode; selected slave then sends no character or strobe downstream
// - unique match clears first transmit stage, line high if clear to send
// - ENQ clears second stage; it sets again at t2 of next character
// - when second stage sets at t2, first stage captures address mode
// - STX right after ENQ makes first stage capture cleared state, enabled
// - ETX sets address mode without deselecting; stages act as for ENQ
// - last unique slave stays enabled unless a dummy address follows
// - wake-up gives data mode, clears flags, sets both transmit stages
// - acknowledge substitute is code 006 octal
// - command codes use standard ascii values
// - zero level from other options on keystroke-inhibit line is overridden only by master
`timescale 1ns/1ps
module msa_selective_addressing #(
  parameter int SHIFT_CYCLES = msa_pkg::MSA_SHIFT_CYCLES
) (
  input wire logic i_clk, // system clock, 100 MHz
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_wake_up, // power-on wake-up pulse, active high
  input wire msa_pkg::msa_char_s i_rx, // received char and received_char_valid
  input wire msa_pkg::msa_char_s i_kbd, // local keyboard code and strobe
  input wire logic [6:0] i_unique_address_switch, // unique address setting
  input wire logic [6:0] i_group_address_switch, // group address setting
  input wire logic i_clear_to_send, // modem interface clear to send
  input wire logic i_local, // terminal switched to local
  input wire logic i_line_other_zero, // other options pull the line to zero
  output msa_pkg::msa_char_s o_tx, // char and strobe to downstream options
  output logic o_receiver_output_enable, // uart output enable to logic board
  output logic o_keystroke_inhibit_line, // high level enables keyboard
  output msa_pkg::msa_status_s o_status // flags and lamps
);
  import msa_pkg::*;

  logic [3:0] slot;
  logic master;
  logic network_free_flag;
  logic selected;
  logic address_mode;
  logic xmit1;
  logic xmit2;
  logic rx_seen;
  logic [6:0] rx_code;
  logic decode_win;
  logic is_eot;
  logic is_null;
  logic is_stx;
  logic is_etx;
  logic is_enq;
  logic is_bell;
  logic unique_hit;
  logic group_hit;
  logic addr_hit;
  logic kbd_eot;
  logic take_master;
  logic substitute;
  logic next_line;
  logic hold_stage2;

  // timing sequencer for each received character
  msa_sequencer #(
    .SHIFT_CYCLES(SHIFT_CYCLES)
  ) u_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(i_rx.valid),
    .o_slot(slot)
  );

  // hold the received code for the whole sequence
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_code <= '0;
    end else if (i_rx.valid) begin
      rx_code <= i_rx.code;
    end
  end

  // decode window at slots t1 and t3 and function decoder
  assign decode_win = slot[MSA_SLOT_T1] | slot[MSA_SLOT_T3];
  assign is_eot = decode_win && (rx_code == MSA_CODE_EOT);
  assign is_null = decode_win && (rx_code == MSA_CODE_NULL);
  assign is_stx = decode_win && (rx_code == MSA_CODE_STX);
  assign is_etx = decode_win && (rx_code == MSA_CODE_ETX);
  assign is_enq = decode_win && (rx_code == MSA_CODE_ENQ);
  assign is_bell = (rx_code == MSA_CODE_BELL);

  // address comparators, only armed in address mode
  assign unique_hit = address_mode && (rx_code == i_unique_address_switch);
  assign group_hit = address_mode && (rx_code == i_group_address_switch);
  assign addr_hit = decode_win && (unique_hit || group_hit || (address_mode && is_bell));

  // ENQ or ETX in the sequence: stage 2 stays clear until the next character's t2
  assign hold_stage2 = (rx_code == MSA_CODE_ENQ) || (rx_code == MSA_CODE_ETX);

  // keyboard EOT gated by network-free and nothing received yet
  assign kbd_eot = i_kbd.valid && (i_kbd.code == MSA_CODE_EOT);
  assign take_master = kbd_eot && !network_free_flag && !rx_seen && !master;

  // record that a character arrived since wake-up
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_seen <= MSA_RX_SEEN_RST;
    end else if (i_wake_up) begin
      rx_seen <= MSA_RX_SEEN_RST;
    end else if (i_rx.valid) begin
      rx_seen <= 1'b1;
    end
  end

  // master flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master <= MSA_MASTER_RST;
    end else if (i_wake_up || is_eot) begin
      master <= 1'b0;
    end else if (take_master) begin
      master <= 1'b1;
    end
  end

  // network-free flag (set means network taken, lamp off)
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      network_free_flag <= MSA_NETFREE_RST;
    end else if (i_wake_up || is_eot) begin
      network_free_flag <= 1'b0;
    end else if (slot[MSA_SLOT_T2]) begin
      network_free_flag <= !master;
    end
  end

  // selected flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      selected <= MSA_SELECTED_RST;
    end else if (i_wake_up || is_eot) begin
      selected <= 1'b0;
    end else if (take_master || addr_hit) begin
      selected <= 1'b1;
    end
  end

  // address mode flag; EOT, NULL, ETX set, STX clears
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      address_mode <= MSA_ADDR_MODE_RST;
    end else if (i_wake_up) begin
      address_mode <= 1'b0;
    end else if (is_eot || is_null || is_etx) begin
      address_mode <= 1'b1;
    end else if (is_stx) begin
      address_mode <= 1'b0;
    end
  end

  // second transmit stage: ENQ or ETX clear, set again at next t2
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xmit2 <= MSA_XMIT2_RST;
    end else if (i_wake_up) begin
      xmit2 <= 1'b1;
    end else if (is_enq || is_etx) begin
      xmit2 <= 1'b0;
    end else if (slot[MSA_SLOT_T2] && !xmit2 && !hold_stage2) begin
      xmit2 <= 1'b1;
    end
  end

  // first transmit stage: unique clears, captures address mode on stage 2 set
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xmit1 <= MSA_XMIT1_RST;
    end else if (i_wake_up) begin
      xmit1 <= 1'b1;
    end else if (decode_win && unique_hit) begin
      xmit1 <= 1'b0;
    end else if (slot[MSA_SLOT_T2] && !xmit2 && !hold_stage2) begin
      xmit1 <= address_mode;
    end
  end

  // substitute when unselected non-master, or in address mode except ENQ
  assign substitute = (!master && !selected) || (address_mode && rx_code != MSA_CODE_ENQ);

  // downstream character, strobe and uart enable at t4
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx <= '0;
      o_receiver_output_enable <= 1'b1;
    end else if (slot[MSA_SLOT_T4] && substitute) begin
      o_tx.valid <= 1'b1;
      o_tx.code <= MSA_CODE_ACK;
      o_receiver_output_enable <= 1'b0;
    end else begin
      o_tx.valid <= 1'b0;
      o_tx.code <= '0;
      o_receiver_output_enable <= 1'b1;
    end
  end

  // keystroke-inhibit line level: high only for master, local, or enabled unique slave
  always_comb begin
    if (i_local || master) begin
      next_line = !i_line_other_zero || master;
    end else if (!xmit1) begin
      next_line = i_clear_to_send && !i_line_other_zero;
    end else begin
      next_line = 1'b0;
    end
  end

  // registered line and status outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_keystroke_inhibit_line <= 1'b0;
      o_status <= '0;
    end else begin
      o_keystroke_inhibit_line <= next_line;
      o_status.master <= master;
      o_status.network_free_flag <= network_free_flag;
      o_status.selected <= selected;
      o_status.selected_lamp <= selected && next_line;
      o_status.address_mode <= address_mode;
    end
  end
endmodule // msa_selective_addressing

// *** msa_pkg.sv ***
// package: codes, sequencer slots, timing and carrier structs for selective addressing
package msa_pkg;
  localparam int MSA_CHAR_W = 7;
  localparam logic [6:0] MSA_CODE_NULL = 7'h00;
  localparam logic [6:0] MSA_CODE_STX = 7'h02;
  localparam logic [6:0] MSA_CODE_ETX = 7'h03;
  localparam logic [6:0] MSA_CODE_EOT = 7'h04;
  localparam logic [6:0] MSA_CODE_ENQ = 7'h05;
  localparam logic [6:0] MSA_CODE_ACK = 7'h06;
  localparam logic [6:0] MSA_CODE_BELL = 7'h07;
  // sequencer slot positions inside the one-hot stage vector
  localparam int MSA_SLOT_T1 = 0;
  localparam int MSA_SLOT_T2 = 1;
  localparam int MSA_SLOT_T3 = 2;
  localparam int MSA_SLOT_T4 = 3;
  localparam int MSA_SEQ_STAGES = 4;
  localparam logic [3:0] MSA_SEQ_RESET = 4'h0;
  // shift period and its count of 10 ns cycles (rounded down, at least one)
  localparam int MSA_CLK_PERIOD_PS = 10000;
  localparam int MSA_SHIFT_PERIOD_PS = 1200000;
  localparam int MSA_SHIFT_CYCLES_RAW = MSA_SHIFT_PERIOD_PS / MSA_CLK_PERIOD_PS;
  localparam int MSA_SHIFT_CYCLES = (MSA_SHIFT_CYCLES_RAW < 1) ? 1 : MSA_SHIFT_CYCLES_RAW;
  // reset values of the state flags
  localparam logic MSA_MASTER_RST = 1'b0;
  localparam logic MSA_NETFREE_RST = 1'b0;
  localparam logic MSA_SELECTED_RST = 1'b0;
  localparam logic MSA_ADDR_MODE_RST = 1'b0;
  localparam logic MSA_XMIT1_RST = 1'b1;
  localparam logic MSA_XMIT2_RST = 1'b1;
  localparam logic MSA_RX_SEEN_RST = 1'b0;

  // character with its valid strobe
  typedef struct packed {
    logic valid;
    logic [6:0] code;
  } msa_char_s;

  // front panel and network status bundle
  typedef struct packed {
    logic master;
    logic network_free_flag;
    logic selected;
    logic selected_lamp;
    logic address_mode;
  } msa_status_s;
endpackage

// *** msa_sequencer.sv ***
// four-stage one-hot timing sequencer stepping at the option clock rate
`timescale 1ns/1ps
module msa_sequencer #(
  parameter int SHIFT_CYCLES = msa_pkg::MSA_SHIFT_CYCLES
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_start, // received character valid
  output logic [3:0] o_slot // one-hot slots t1..t4, pulse per stage
);
  import msa_pkg::*;

  localparam int CNT_W = (SHIFT_CYCLES > 1) ? $clog2(SHIFT_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SHIFT_CYCLES - 1);

  logic [3:0] stage;
  logic [CNT_W-1:0] div;
  logic tick;
  logic running;

  // option clock tick and running condition
  assign tick = (div == CNT_LAST);
  assign running = |stage;

  // option clock divider, restarted by each strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div <= '0;
    end else if (i_start || !running || tick) begin
      div <= '0;
    end else begin
      div <= div + CNT_W'(1);
    end
  end

  // stage register: load t1, then shift once per tick, drop out after t4
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage <= MSA_SEQ_RESET;
    end else if (i_start) begin
      stage <= 4'h1;
    end else if (tick) begin
      stage <= {stage[2:0], 1'b0};
    end
  end

  // each slot pulses for one cycle at the start of its stage
  logic [3:0] stage_d;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_d <= MSA_SEQ_RESET;
    end else begin
      stage_d <= stage;
    end
  end
  assign o_slot = stage & ~stage_d;
endmodule // msa_sequencer

// *** msa_uart_model.sv ***
// receiver-side model: one-cycle character strobes into the block
`timescale 1ns/1ps
module msa_uart_model
  import msa_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_send, // send request from bench
  input wire logic [6:0] i_code, // code to send
  output msa_char_s o_rx // char and valid to block
);
  logic [6:0] last;
  // one-cycle valid; idle lines show the inverse of the last code
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx <= '0;
      last <= 7'h00;
    end else if (i_send) begin
      o_rx <= {1'b1, i_code};
      last <= i_code;
    end else begin
      o_rx <= {1'b0, ~last};
    end
  end
endmodule // msa_uart_model

// *** msa_monitor.sv ***
// checker: port assertions for the selective addressing block
`timescale 1ns/1ps
module msa_monitor
  import msa_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_wake_up, // wake-up pulse
  input wire msa_char_s i_rx, // received char
  input wire logic i_local, // local mode
  input wire msa_char_s o_tx, // downstream char
  input wire logic o_receiver_output_enable, // uart enable
  input wire logic o_keystroke_inhibit_line, // inhibit line
  input wire msa_status_s o_status // flags and lamps
);
  logic [4:0] since_rx;
  // cycles since the last received strobe, saturating
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) since_rx <= 5'h1F;
    else if (i_rx.valid) since_rx <= 5'h00;
    else if (since_rx != 5'h1F) since_rx <= since_rx + 5'h01;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_ack_code: assert property (o_tx.valid |-> o_tx.code == MSA_CODE_ACK)
    else $error("substituted code wrong");
  a_enable_drop: assert property (o_tx.valid |-> !o_receiver_output_enable ##1 o_receiver_output_enable)
    else $error("uart enable not dropped with ack");
  a_ack_latency: assert property (o_tx.valid |-> since_rx inside {[10:20]})
    else $error("ack strobe at wrong slot");
  a_strobe_single: assert property (o_tx.valid |=> !o_tx.valid)
    else $error("ack strobe too long");
  a_lamp_select: assert property (o_status.selected_lamp |-> o_status.selected)
    else $error("lamp lit while unselected");
  a_master_line: assert property (o_status.master && $past(o_status.master) |-> o_keystroke_inhibit_line)
    else $error("master with line low");
  a_local_line: assert property (i_local ##1 i_local |-> o_keystroke_inhibit_line)
    else $error("local with line low");
  a_wake_clear: assert property (i_wake_up |-> ##2 !(o_status.master || o_status.selected || o_status.address_mode))
    else $error("wake-up left flags set");
endmodule // msa_monitor
bind msa_selective_addressing msa_monitor msa_monitor_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_wake_up(i_wake_up), .i_rx(i_rx), .i_local(i_local), .o_tx(o_tx),
  .o_receiver_output_enable(o_receiver_output_enable),
  .o_keystroke_inhibit_line(o_keystroke_inhibit_line), .o_status(o_status));

// *** msa_selective_addressing_tb.sv ***
// testbench: command and address sequences with expected outputs
`timescale 1ns/1ps
module msa_selective_addressing_tb;
  import msa_pkg::*;
  localparam logic [6:0] UNIQ = 7'h55;
  localparam logic [6:0] GRP = 7'h47;
  logic i_clk, i_rst_n, i_wake_up, i_clear_to_send, i_local, i_line_other_zero, send;
  logic o_receiver_output_enable, o_keystroke_inhibit_line;
  logic [6:0] code;
  msa_char_s i_rx, i_kbd, o_tx;
  msa_status_s o_status;
  int miscompares = 0, checks = 0, acks;
  msa_uart_model msa_uart_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_send(send),
    .i_code(code), .o_rx(i_rx));
  msa_selective_addressing #(.SHIFT_CYCLES(4)) msa_selective_addressing_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_wake_up(i_wake_up), .i_rx(i_rx), .i_kbd(i_kbd),
    .i_unique_address_switch(UNIQ), .i_group_address_switch(GRP),
    .i_clear_to_send(i_clear_to_send), .i_local(i_local),
    .i_line_other_zero(i_line_other_zero), .o_tx(o_tx),
    .o_receiver_output_enable(o_receiver_output_enable),
    .o_keystroke_inhibit_line(o_keystroke_inhibit_line), .o_status(o_status));
  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // exp: 0 no strobe, 1 one ack strobe, 2 not checked
  task automatic send_char(input logic [6:0] c, input int exp);
    acks = 0;
    code = c;
    send = 1'b1;
    tick(1);
    send = 1'b0;
    repeat (24) begin
      tick(1);
      if (o_tx.valid === 1'b1) begin
        acks++;
        chk("tx code", MSA_CODE_ACK, o_tx.code);
      end
    end
    if (exp < 2) chk("ack count", 7'(exp), 7'(acks));
  endtask
  task automatic kbd(input logic [6:0] c);
    i_kbd = {1'b1, c};
    tick(1);
    i_kbd = '0;
    tick(3);
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    miscompares++;
    stop_test;
  end
  // main sequence
  initial begin
    {i_rst_n, i_wake_up, i_local, i_line_other_zero, send} = '0;
    i_clear_to_send = 1'b1;
    code = 7'h00;
    i_kbd = '0;
    tick(10);
    i_rst_n = 1'b1;
    tick(1);
    chk("status", 7'h00, 7'(o_status));
    chk("uart enable", 7'h01, 7'(o_receiver_output_enable));
    $display("test reset done");
    send_char(7'h41, 1);
    chk("net free", 7'h01, 7'(o_status.network_free_flag));
    kbd(MSA_CODE_EOT);
    chk("master", 7'h00, 7'(o_status.master));
    $display("test unselected done");
    send_char(MSA_CODE_NULL, 1);
    chk("addr mode", 7'h01, 7'(o_status.address_mode));
    send_char(GRP, 1);
    chk("selected", 7'h01, 7'(o_status.selected));
    chk("line", 7'h00, 7'(o_keystroke_inhibit_line));
    chk("lamp", 7'h00, 7'(o_status.selected_lamp));
    send_char(MSA_CODE_STX, 2);
    chk("addr mode", 7'h00, 7'(o_status.address_mode));
    send_char(7'h42, 0);
    send_char(MSA_CODE_EOT, 1);
    chk("status", 7'h01, 7'(o_status));
    $display("test group done");
    send_char(MSA_CODE_NULL, 1);
    send_char(UNIQ, 1);
    chk("line", 7'h01, 7'(o_keystroke_inhibit_line));
    send_char(MSA_CODE_ENQ, 0);
    send_char(MSA_CODE_STX, 2);
    chk("line", 7'h01, 7'(o_keystroke_inhibit_line));
    i_clear_to_send = 1'b0;
    tick(2);
    chk("line", 7'h00, 7'(o_keystroke_inhibit_line));
    i_clear_to_send = 1'b1;
    tick(2);
    chk("line", 7'h01, 7'(o_keystroke_inhibit_line));
    $display("test two-way done");
    send_char(MSA_CODE_NULL, 1);
    send_char(UNIQ, 1);
    send_char(MSA_CODE_ENQ, 0);
    send_char(7'h58, 1);
    chk("line", 7'h00, 7'(o_keystroke_inhibit_line));
    send_char(MSA_CODE_BELL, 1);
    send_char(MSA_CODE_ETX, 1);
    chk("selected", 7'h01, 7'(o_status.selected));
    chk("addr mode", 7'h01, 7'(o_status.address_mode));
    $display("test one-way done");
    i_local = 1'b1;
    tick(3);
    chk("line", 7'h01, 7'(o_keystroke_inhibit_line));
    i_local = 1'b0;
    i_wake_up = 1'b1;
    tick(1);
    i_wake_up = 1'b0;
    tick(3);
    chk("status", 7'h00, 7'(o_status));
    kbd(MSA_CODE_EOT);
    chk("master", 7'h01, 7'(o_status.master));
    chk("selected", 7'h01, 7'(o_status.selected));
    chk("line", 7'h01, 7'(o_keystroke_inhibit_line));
    chk("lamp", 7'h01, 7'(o_status.selected_lamp));
    send_char(MSA_CODE_EOT, 1);
    chk("master", 7'h00, 7'(o_status.master));
    chk("selected", 7'h00, 7'(o_status.selected));
    $display("test master done");
    stop_test;
  end
endmodule // msa_selective_addressing_tb
